// File: scg_gate_cell.sv
`timescale 1ns/1ps
`default_nettype none
// one gated peripheral clock; latch-free enable captured on the low phase
module scg_gate_cell (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // enable in, gated clock out
  input wire logic en_i,
  output logic gclk_o
);
  logic en_reg; // enable held while clock is low to avoid glitches

  // capture on falling edge so the and gate sees a stable enable
  always_ff @(negedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      en_reg <= 1'b0;
    end else begin
      en_reg <= en_i;
    end
  end

  assign gclk_o = clk_i & en_reg;
endmodule
`default_nettype wire

// File: scg_pkg.sv
package scg_pkg;
  // register byte offsets on the apb slave
  localparam logic [11:0] SCG_RUN_OFS = 12'h104;
  localparam logic [11:0] SCG_SLEEP_OFS = 12'h114;
  localparam logic [11:0] SCG_DEEP_OFS = 12'h124;
  localparam logic [11:0] SCG_CFG_OFS = 12'h060;
  localparam logic [11:0] SCG_IRQ_STAT_OFS = 12'h200;
  localparam logic [11:0] SCG_IRQ_MASK_OFS = 12'h204;
  // writable bits of each gating register
  localparam logic [31:0] SCG_GATE_MASK = 32'h030f5033;
  localparam logic [31:0] SCG_GATE_RESET = 32'h00000000;
  // automatic gating select bit in the run clock configuration register
  localparam int SCG_AUTO_BIT = 27;
  localparam logic [31:0] SCG_CFG_MASK = 32'h08000000;
  localparam logic [31:0] SCG_CFG_RESET = 32'h00000000;
  // interrupt status bits
  localparam int SCG_IRQ_W = 2;
  localparam int SCG_EV_FAULT = 0;
  localparam int SCG_EV_STATE = 1;
  localparam logic [1:0] SCG_IRQ_ZERO = 2'h0;
  // peripheral window decode
  localparam int SCG_NPERIPH = 32;
  localparam int SCG_PSEL_W = 5;
  // power states
  typedef enum logic [1:0] {
    SCG_PWR_RUN,
    SCG_PWR_SLEEP,
    SCG_PWR_DEEP
  } scg_pwr_t;
endpackage

// File: scg_top.sv
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
//
// Contract
// - each set bit clocks its peripheral
// - access to gated peripheral gives bus fault
// - gating registers reset to zero
// - separate gating set per power state
// - sleep sets used only with auto select
// - counter enables at bits 19 to 16
// - two wire enables at 14 and 12
// - sync serial enables at 5 and 4
// - async port enables at 1 and 0
// - reserved bits read zero, ignore writes
module scg_top
  import scg_pkg::*;
(
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RST_I,
  // apb slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [11:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // power state from the system controller
  input wire logic SLEEP_I,
  input wire logic DEEP_SLEEP_I,
  // peripheral bus access monitor
  input wire logic PERIPH_REQ_I,
  input wire logic [4:0] PERIPH_SEL_I,
  output logic PERIPH_FAULT_O,
  // gated clocks and enables
  output logic [31:0] PERIPH_EN_O,
  output logic [31:0] PERIPH_CLK_O,
  // interrupt
  output logic IRQ_O
);
  // gating registers, one set per power state
  logic [31:0] run_gate_reg, run_gate_next;
  logic [31:0] sleep_gate_reg, sleep_gate_next;
  logic [31:0] deep_gate_reg, deep_gate_next;
  logic [31:0] cfg_reg, cfg_next;
  logic [SCG_IRQ_W-1:0] stat_reg, stat_next;
  logic [SCG_IRQ_W-1:0] mask_reg, mask_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pslverr_reg, pslverr_next;
  logic fault_reg; // fault answer held one cycle
  scg_pwr_t state_reg, state_next;
  logic [31:0] active_en; // enables applied right now

  // apb decode; zero wait states
  wire setup_ph = PSEL_I & ~PENABLE_I;
  wire access_ph = PSEL_I & PENABLE_I;
  wire wr_en = access_ph & PWRITE_I;
  wire rd_setup = setup_ph & ~PWRITE_I;
  // one full address compare per register; partial decode would alias
  wire hit_run = PADDR_I == SCG_RUN_OFS;
  wire hit_sleep = PADDR_I == SCG_SLEEP_OFS;
  wire hit_deep = PADDR_I == SCG_DEEP_OFS;
  wire hit_cfg = PADDR_I == SCG_CFG_OFS;
  wire hit_stat = PADDR_I == SCG_IRQ_STAT_OFS;
  wire hit_mask = PADDR_I == SCG_IRQ_MASK_OFS;
  // any miss is answered with an error in the access phase
  wire hit_any = hit_run | hit_sleep | hit_deep | hit_cfg | hit_stat | hit_mask;
  // automatic gating select from the run clock configuration
  wire auto_sel = cfg_reg[SCG_AUTO_BIT];
  wire [31:0] wgate = PWDATA_I & SCG_GATE_MASK; // reserved bits dropped

  // register next values; writes land in the access phase
  assign run_gate_next = (wr_en & hit_run) ? wgate : run_gate_reg;
  assign sleep_gate_next = (wr_en & hit_sleep) ? wgate : sleep_gate_reg;
  assign deep_gate_next = (wr_en & hit_deep) ? wgate : deep_gate_reg;
  assign cfg_next = (wr_en & hit_cfg) ? (PWDATA_I & SCG_CFG_MASK) : cfg_reg;
  assign mask_next = (wr_en & hit_mask) ? PWDATA_I[SCG_IRQ_W-1:0] : mask_reg;

  // power state: sleep modes only honoured with automatic gating
  always_comb begin
    // run set unless a sleep request stands with auto select on
    state_next = SCG_PWR_RUN;
    // deep sleep wins when both requests stand
    if (auto_sel & DEEP_SLEEP_I) begin
      state_next = SCG_PWR_DEEP;
    end else if (auto_sel & SLEEP_I) begin
      state_next = SCG_PWR_SLEEP;
    end
  end

  // select the enable set for the current state
  always_comb begin
    case (state_reg)
      SCG_PWR_RUN: active_en = run_gate_reg;
      SCG_PWR_SLEEP: active_en = sleep_gate_reg;
      SCG_PWR_DEEP: active_en = deep_gate_reg;
      // unused encoding falls back to the run set
      default: active_en = run_gate_reg;
    endcase
  end

  // events: bus fault and power-state change; set wins over clear
  // the applied set decides, so a sleep access is judged by the sleep set
  wire periph_fault = PERIPH_REQ_I & ~active_en[PERIPH_SEL_I];
  // one event line per status bit
  wire [SCG_IRQ_W-1:0] ev;
  assign ev[SCG_EV_FAULT] = periph_fault;
  assign ev[SCG_EV_STATE] = state_next != state_reg;
  wire [SCG_IRQ_W-1:0] w1c = (wr_en & hit_stat) ? PWDATA_I[SCG_IRQ_W-1:0] : SCG_IRQ_ZERO;
  assign stat_next = (stat_reg & ~w1c) | ev;

  // read mux, captured in setup so data comes from a flop
  always_comb begin
    prdata_next = 32'h00000000;
    if (rd_setup) begin
      // gating sets hold zeros in their reserved bits already
      if (hit_run) begin
        prdata_next = run_gate_reg;
      end else if (hit_sleep) begin
        // sleep set
        prdata_next = sleep_gate_reg;
      end else if (hit_deep) begin
        // deep sleep set
        prdata_next = deep_gate_reg;
      end else if (hit_cfg) begin
        // only the auto select bit can be set here
        prdata_next = cfg_reg;
      end else if (hit_stat) begin
        // status bits zero extended
        prdata_next = {30'h0, stat_reg};
      end else if (hit_mask) begin
        // mask bits zero extended
        prdata_next = {30'h0, mask_reg};
      end
    end
  end
  assign pslverr_next = setup_ph & ~hit_any; // unmapped address answers error

  // all registers clear on reset
  // the reset branch loads constants only, so release is clean
  always_ff @(posedge CLOCK_I or posedge RST_I) begin
    if (RST_I) begin
      run_gate_reg <= SCG_GATE_RESET;
      sleep_gate_reg <= SCG_GATE_RESET;
      deep_gate_reg <= SCG_GATE_RESET;
      cfg_reg <= SCG_CFG_RESET;
      stat_reg <= SCG_IRQ_ZERO;
      mask_reg <= SCG_IRQ_ZERO;
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
      fault_reg <= 1'b0;
      state_reg <= SCG_PWR_RUN;
    end else begin
      run_gate_reg <= run_gate_next;
      sleep_gate_reg <= sleep_gate_next;
      deep_gate_reg <= deep_gate_next;
      cfg_reg <= cfg_next;
      stat_reg <= stat_next;
      mask_reg <= mask_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
      fault_reg <= periph_fault;
      state_reg <= state_next;
    end
  end

  // per-peripheral gated clock cells
  genvar gi;
  generate
    for (gi = 0; gi < SCG_NPERIPH; gi++) begin : g_cell
      scg_gate_cell u_cell (
        .clk_i(CLOCK_I),
        .rst_i(RST_I),
        .en_i(active_en[gi]),
        .gclk_o(PERIPH_CLK_O[gi])
      );
      // the high phase follows the enable seen at the last falling edge
      a_clk_follow: assert property (@(negedge CLOCK_I) disable iff (RST_I)
        PERIPH_CLK_O[gi] == $past(active_en[gi])) else $error("gated clock wrong");
    end
  endgenerate

  // outputs
  // enables leave as levels; peripherals that need a clean edge use the gated clock
  assign PERIPH_EN_O = active_en;
  assign PERIPH_FAULT_O = fault_reg;
  assign PRDATA_O = prdata_reg;
  assign PSLVERR_O = pslverr_reg;
  // every access completes in one access cycle
  assign PREADY_O = 1'b1; // no wait states
  // level interrupt, no edge memory of its own
  assign IRQ_O = |(stat_reg & mask_reg);

  // checks
  a_reserved_zero: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (sleep_gate_reg & ~SCG_GATE_MASK) == 32'h0) else $error("reserved sleep bit set");
  a_fault_gated: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    PERIPH_REQ_I && !PERIPH_EN_O[PERIPH_SEL_I] |=> PERIPH_FAULT_O) else $error("missing bus fault");
  a_fault_ok: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    PERIPH_REQ_I && PERIPH_EN_O[PERIPH_SEL_I] |=> !PERIPH_FAULT_O) else $error("spurious bus fault");
  a_sleep_select: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    state_reg == SCG_PWR_SLEEP |-> PERIPH_EN_O == sleep_gate_reg) else $error("wrong sleep set");
  a_no_auto: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    !auto_sel |=> state_reg == SCG_PWR_RUN) else $error("sleep set used without auto");
  a_write_sleep: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    wr_en && hit_sleep |=> sleep_gate_reg == ($past(PWDATA_I) & SCG_GATE_MASK)) else $error("sleep write lost");
  sequence s_wr_sleep;
    wr_en && hit_sleep && !PWDATA_I[24];
  endsequence
  a_comp_clear: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    s_wr_sleep ##1 1'b1 |-> !sleep_gate_reg[24]) else $error("comparator bit kept");
  a_irq_level: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    periph_fault && mask_reg[SCG_EV_FAULT] && !(wr_en && hit_mask) |=> IRQ_O) else $error("irq level wrong");
  a_bit_map: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    wr_en && hit_sleep && PWDATA_I[14] |=> sleep_gate_reg[14] && !sleep_gate_reg[13]) else $error("two wire bit");
  a_ser_map: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    wr_en && hit_sleep && PWDATA_I[5] |=> sleep_gate_reg[5]) else $error("sync serial bit");
  a_uart_map: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    wr_en && hit_sleep && PWDATA_I[0] |=> sleep_gate_reg[0]) else $error("async port bit");
  a_reset_zero: assert property (@(posedge CLOCK_I)
    $fell(RST_I) |-> sleep_gate_reg == SCG_GATE_RESET) else $error("reset value wrong");

  // bus phases reused by the read, write and error checks
  sequence s_rd_setup;
    PSEL_I && !PENABLE_I && !PWRITE_I;
  endsequence
  sequence s_wr_access;
    PSEL_I && PENABLE_I && PWRITE_I;
  endsequence
  sequence s_rd_miss;
    s_rd_setup ##0 !hit_any;
  endsequence

  // run set read back in the access phase
  a_run_read: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    s_rd_setup ##0 hit_run |=> PRDATA_O == $past(run_gate_reg)) else $error("run read wrong");

  // sleep set read back in the access phase
  a_sleep_read: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    s_rd_setup ##0 hit_sleep |=> PRDATA_O == $past(sleep_gate_reg)) else $error("sleep read wrong");

  // deep sleep set read back in the access phase
  a_deep_read: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    s_rd_setup ##0 hit_deep |=> PRDATA_O == $past(deep_gate_reg)) else $error("deep read wrong");

  // reserved bits of any gating set read as zero
  a_read_resvd: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    s_rd_setup ##0 (hit_run || hit_sleep || hit_deep) |=> (PRDATA_O & ~SCG_GATE_MASK) == 32'h00000000)
    else $error("reserved read set");

  // run set never holds a reserved bit
  a_run_resvd: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (run_gate_reg & ~SCG_GATE_MASK) == 32'h00000000) else $error("reserved run bit set");

  // deep set never holds a reserved bit
  a_deep_resvd: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (deep_gate_reg & ~SCG_GATE_MASK) == 32'h00000000) else $error("reserved deep bit set");

  // configuration keeps only the auto select bit
  a_cfg_resvd: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    (cfg_reg & ~SCG_CFG_MASK) == 32'h00000000) else $error("reserved config bit set");

  // a miss reads zero with an error
  a_miss_read: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    s_rd_miss |=> PSLVERR_O && PRDATA_O == 32'h00000000) else $error("miss not refused");

  // a write that misses leaves the sleep set alone
  a_miss_keep: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    s_wr_access ##0 !hit_any |=> sleep_gate_reg == $past(sleep_gate_reg)) else $error("miss wrote");

  // a run write touches no other set
  a_run_apart: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    s_wr_access ##0 hit_run |=> sleep_gate_reg == $past(sleep_gate_reg) && deep_gate_reg == $past(deep_gate_reg))
    else $error("run write leaked");

  // a deep write touches no other set
  a_deep_apart: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    s_wr_access ##0 hit_deep |=> sleep_gate_reg == $past(sleep_gate_reg) && run_gate_reg == $past(run_gate_reg))
    else $error("deep write leaked");

  // deep state applies the deep set
  a_deep_select: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    state_reg == SCG_PWR_DEEP |-> PERIPH_EN_O == deep_gate_reg) else $error("wrong deep set");

  // run state applies the run set
  a_run_select: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    state_reg == SCG_PWR_RUN |-> PERIPH_EN_O == run_gate_reg) else $error("wrong run set");

  // deep request with auto select enters deep state
  a_auto_deep: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    auto_sel && DEEP_SLEEP_I |=> state_reg == SCG_PWR_DEEP) else $error("deep not entered");

  // sleep request with auto select enters sleep state
  a_auto_sleep: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    auto_sel && SLEEP_I && !DEEP_SLEEP_I |=> state_reg == SCG_PWR_SLEEP) else $error("sleep not entered");

  // a fault answer always has a request behind it
  a_fault_cause: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    PERIPH_FAULT_O |-> $past(PERIPH_REQ_I)) else $error("fault without request");

  // a fault is recorded in the status bit
  a_fault_stat: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    periph_fault |=> stat_reg[SCG_EV_FAULT]) else $error("fault not recorded");

  // writing one clears the fault bit when no new fault comes
  a_fault_clear: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    s_wr_access ##0 hit_stat && PWDATA_I[SCG_EV_FAULT] && !periph_fault |=> !stat_reg[SCG_EV_FAULT])
    else $error("fault bit not cleared");

  // each power state change is recorded
  a_state_stat: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    state_next != state_reg |=> stat_reg[SCG_EV_STATE]) else $error("state change not recorded");

  // run and deep sets and the applied enables leave reset at zero
  a_reset_sets: assert property (@(posedge CLOCK_I)
    $fell(RST_I) |-> run_gate_reg == SCG_GATE_RESET && deep_gate_reg == SCG_GATE_RESET
    && PERIPH_EN_O == SCG_GATE_RESET) else $error("reset sets wrong");

  // counter enables hold at their four bits
  a_counter_map: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    s_wr_access ##0 hit_sleep && PWDATA_I[19:16] == 4'hf |=> sleep_gate_reg[19:16] == 4'hf) else $error("counter bits");

  // second comparator enable holds
  a_comp_map: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    s_wr_access ##0 hit_sleep && PWDATA_I[25] |=> sleep_gate_reg[25]) else $error("comparator bit");

  // first two wire enable holds
  a_two_wire_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    s_wr_access ##0 hit_sleep && PWDATA_I[12] |=> sleep_gate_reg[12]) else $error("two wire a bit");

  // first sync serial enable holds
  a_sync_a: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    s_wr_access ##0 hit_sleep && PWDATA_I[4] |=> sleep_gate_reg[4]) else $error("sync serial a bit");

  // second async port enable holds
  a_async_b: assert property (@(posedge CLOCK_I) disable iff (RST_I)
    s_wr_access ##0 hit_sleep && PWDATA_I[1] |=> sleep_gate_reg[1]) else $error("async port b bit");
endmodule
`default_nettype wire

// File: test_sleep_mode_clock_gating.sv
`timescale 1ns/1ps
`default_nettype none
module test_sleep_mode_clock_gating import scg_pkg::*; ;
  // writable gate bits from the field layout: comparators, counters, two wire, sync serial, async ports
  localparam logic [31:0] exp_gate = 32'h03000000 | 32'h000f0000 | 32'h00005000 | 32'h00000030 | 32'h00000003;
  // clock, reset and bus drives
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  // power state and peripheral access drives
  logic sleep = 1'b0;
  logic deep = 1'b0;
  logic preq = 1'b0;
  logic [4:0] pidx = 5'h00;
  // design outputs
  wire logic [31:0] prdata;
  wire logic [31:0] en;
  wire logic [31:0] gclk;
  wire logic pready;
  wire logic pslverr;
  wire logic fault;
  wire logic irq;
  // result counters and last transfer answer
  int mismatches = 0;
  int cmp_count = 0;
  logic [31:0] rd;
  logic er;
  logic [11:0] reset_ofs [6] = '{SCG_RUN_OFS, SCG_SLEEP_OFS, SCG_DEEP_OFS, SCG_CFG_OFS, SCG_IRQ_STAT_OFS, SCG_IRQ_MASK_OFS};

  scg_top i_scg_top (
    .CLOCK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .SLEEP_I(sleep), .DEEP_SLEEP_I(deep), .PERIPH_REQ_I(preq), .PERIPH_SEL_I(pidx),
    .PERIPH_FAULT_O(fault), .PERIPH_EN_O(en), .PERIPH_CLK_O(gclk), .IRQ_O(irq)
  );

  // free running 40 MHz clock
  initial begin
    forever #12.5 clk = ~clk;
  end

  // one compare for every 32-bit result, unknowns never match
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // apb transfer: setup, access until pready, answer taken at that same edge
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // bounded wait; a slave that never answers shows up as a pready mismatch
    while (pready !== 1'b1 && n < 16) begin
      @(posedge clk);
      n++;
    end
    chk("pready", 32'h1, {31'h0, pready});
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task automatic rdchk(input string what, input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask

  // registered state selection needs a couple of edges to land
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask

  task give_verdict();
    $display("mismatches=%0d comparisons=%0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // main sequence
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    #1;
    chk("en_reset", 32'h0, en);
    chk("gclk_reset", 32'h0, gclk);
    foreach (reset_ofs[i]) rdchk("reset_value", reset_ofs[i], 32'h0);
    // walking one shows which bits hold and which read zero
    for (int i = 0; i < 32; i++) begin
      wr(SCG_SLEEP_OFS, 32'h1 << i);
      rdchk("sleep_bit", SCG_SLEEP_OFS, (32'h1 << i) & exp_gate);
    end
    wr(SCG_SLEEP_OFS, 32'hffffffff);
    rdchk("sleep_all", SCG_SLEEP_OFS, exp_gate);
    // one distinct enable per power state set
    wr(SCG_RUN_OFS, 32'h10);
    wr(SCG_SLEEP_OFS, 32'h20);
    wr(SCG_DEEP_OFS, 32'h1000);
    sleep <= 1'b1;
    settle();
    chk("sleep_no_auto", 32'h10, en);
    wr(SCG_CFG_OFS, 32'h1 << SCG_AUTO_BIT);
    settle();
    chk("sleep_set", 32'h20, en);
    @(posedge clk);
    deep <= 1'b1;
    settle();
    chk("deep_set", 32'h1000, en);
    @(posedge clk);
    deep <= 1'b0;
    sleep <= 1'b0;
    settle();
    chk("run_set", 32'h10, en);
    rdchk("state_event", SCG_IRQ_STAT_OFS, 32'h2);
    wr(SCG_IRQ_STAT_OFS, 32'h3);
    rdchk("stat_clear", SCG_IRQ_STAT_OFS, 32'h0);
    // only the enabled peripheral sees clock pulses
    @(posedge clk);
    #2;
    chk("gclk_high", 32'h10, gclk);
    @(negedge clk);
    #2;
    chk("gclk_low", 32'h0, gclk);
    // access to a clocked unit, then to a gated one
    @(posedge clk);
    preq <= 1'b1;
    pidx <= 5'd4;
    @(posedge clk);
    pidx <= 5'd5;
    #1;
    chk("fault_clocked", 32'h0, {31'h0, fault});
    @(posedge clk);
    preq <= 1'b0;
    #1;
    chk("fault_gated", 32'h1, {31'h0, fault});
    // fault event raised, masked, unmasked and cleared
    rdchk("stat_fault", SCG_IRQ_STAT_OFS, 32'h1);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(SCG_IRQ_MASK_OFS, 32'h1);
    #1;
    chk("irq_on", 32'h1, {31'h0, irq});
    wr(SCG_IRQ_STAT_OFS, 32'h1);
    #1;
    chk("irq_off", 32'h0, {31'h0, irq});
    // unmapped place answers with an error and leaves registers alone
    xfer(1'b0, 12'h300, 32'h0);
    chk("bad_rd_err", 32'h1, {31'h0, er});
    chk("bad_rd_data", 32'h0, rd);
    xfer(1'b1, 12'h300, 32'hffffffff);
    chk("bad_wr_err", 32'h1, {31'h0, er});
    rdchk("sleep_kept", SCG_SLEEP_OFS, 32'h20);
    chk("ok_err", 32'h0, {31'h0, er});
    give_verdict();
  end

  // hang guard, far beyond the 85 transfers above
  initial begin
    #(25 * 40000);
    mismatches++;
    give_verdict();
  end
endmodule
`default_nettype wire
